/* File: rtl/msd_pkg.sv */
/*
  Shared constants, types and timing figures for the multichannel sound
  sequencer and its DMA supplier.
  Assumes a single 250 MHz clock (aclk) and synchronous active-low reset.
*/
package msd_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int US_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int MIN_PERIOD_US = 3;

  // --------------------------------------------------------------
  // widths and structure
  // --------------------------------------------------------------
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W = 32;
  localparam int BYTES_PER_WORD = 4;
  localparam int NUM_POS = 8;
  localparam int POS_W = 3;
  localparam int PERIOD_W = 8;
  localparam int CODE_W = 7;

  // --------------------------------------------------------------
  // sample byte fields
  // --------------------------------------------------------------
  localparam int SIGN_BIT = 0;
  localparam int POINT_LSB = 1;
  localparam int CHORD_LSB = 5;
  localparam logic [7:0] SILENT_BYTE = 8'h00;

  // --------------------------------------------------------------
  // register offsets of the controller (AXI4-Lite, byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_STEREO = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_DATA = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reset values
  localparam logic [1:0] CHMODE_RESET = 2'h3;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 8'h0A;
  localparam logic [23:0] STEREO_RESET = 24'h924924;

  // channel modes: code n selects 2**n channels
  typedef enum logic [1:0] {
    MSD_CH1 = 2'b00,
    MSD_CH2 = 2'b01,
    MSD_CH4 = 2'b10,
    MSD_CH8 = 2'b11
  } msd_chmode_e;

endpackage

/* File: rtl/msd_if.sv */
/*
  Link between the sound sequencer and its DMA supplier.
  Assumes both ends share aclk; active-low pins are modelled active high.
*/
`timescale 1ns/1ps
interface msd_if;
  logic sound_dma_request;
  logic sound_dma_ack;
  logic [31:0] sound_data;
  logic video_dma_request;
  logic video_dma_ack;

  modport device (
    output sound_dma_request,
    input sound_dma_ack,
    input sound_data,
    output video_dma_request,
    input video_dma_ack
  );
  modport supplier (
    input sound_dma_request,
    output sound_dma_ack,
    output sound_data,
    input video_dma_request,
    output video_dma_ack
  );
endinterface

/* File: rtl/msd_sequencer.sv */
/*
  Sound sequencer end: word FIFO, byte latch, chord/point decode, sign
  steering, slot timing and stereo time split.
  Assumes the supplier holds data valid while it pulses sound_dma_ack.
*/
`timescale 1ns/1ps
module msd_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link to supplier
  msd_if.device link,
  // control
  input wire logic [1:0] chan_mode,
  input wire logic [msd_pkg::PERIOD_W-1:0] sample_period_register,
  input wire logic [3*msd_pkg::NUM_POS-1:0] stereo_pos,
  input wire logic video_request_in,
  // outputs
  output logic [msd_pkg::CODE_W-1:0] dac_code,
  output logic pair_plus,
  output logic pair_minus,
  output logic side_right,
  output logic mute,
  output logic [3:0] sound_digital_out,
  output logic [3:0] video_digital_out,
  output logic [2:0] cur_chan,
  output logic slot_pulse
);
  import msd_pkg::*;

  // ------------------------------------------------------------------
  // fifo
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [2:0] fifo_cnt;
  logic [1:0] byte_idx;
  logic ack_q;
  logic vack_q;
  logic vreq;
  wire ack_rise = link.sound_dma_ack & ~ack_q;
  wire fifo_full = (fifo_cnt == 3'(FIFO_DEPTH));
  wire fifo_empty = (fifo_cnt == 3'h0);

  // ------------------------------------------------------------------
  // slot timing
  // ------------------------------------------------------------------
  logic [7:0] us_cnt;
  logic [PERIOD_W-1:0] per_cnt;
  logic [15:0] slot_cyc;
  logic [15:0] slot_len;
  logic [7:0] latch;
  logic latch_valid;
  logic [2:0] seq_cnt;
  wire us_tick = (us_cnt == 8'(CYC_PER_US - 1));
  wire [PERIOD_W-1:0] eff_period = (sample_period_register < PERIOD_W'(MIN_PERIOD_US)) ?
    PERIOD_W'(MIN_PERIOD_US) : sample_period_register;
  // >= so a period cut below the running count ends the slot at the next microsecond tick
  wire slot_end = us_tick && (per_cnt >= eff_period - PERIOD_W'(1));
  wire take_byte = slot_end;
  wire pop_word = take_byte && !fifo_empty && (byte_idx == 2'h3);
  wire push = ack_rise && !fifo_full;
  wire [WORD_W-1:0] head = fifo_mem[rd_ptr];
  wire [7:0] next_byte = fifo_empty ? SILENT_BYTE : head[8*byte_idx +: 8];

  // channel index masked by mode; code n gives 2**n channels
  wire [2:0] chan_mask = (chan_mode == MSD_CH8) ? 3'h7 :
                         (chan_mode == MSD_CH4) ? 3'h3 :
                         (chan_mode == MSD_CH2) ? 3'h1 : 3'h0;
  wire [2:0] pos = stereo_pos[3*seq_cnt +: 3];
  // left portion of the unmuted three quarters shrinks as pos grows
  wire [15:0] quarter = 16'(eff_period) * 16'(CYC_PER_US / 4);
  wire [15:0] live = slot_len - quarter;
  wire [18:0] left_len = ({3'h0, live} * 19'(7 - int'(pos))) >> 3;
  // mute follows the byte actually latched, not the fifo of the moment
  wire in_mute = (slot_cyc < quarter) || !latch_valid;
  wire on_right = ({3'h0, slot_cyc} >= {3'h0, quarter} + left_len);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      fifo_cnt <= 3'h0;
      byte_idx <= 2'h0;
      ack_q <= 1'b0;
      vack_q <= 1'b0;
      vreq <= 1'b0;
    end else begin
      ack_q <= link.sound_dma_ack;
      vack_q <= link.video_dma_ack;
      if (push) begin
        fifo_mem[wr_ptr] <= link.sound_data;
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (pop_word)
        rd_ptr <= rd_ptr + 2'h1;
      fifo_cnt <= fifo_cnt + 3'(push) - 3'(pop_word);
      if (take_byte && !fifo_empty)
        byte_idx <= byte_idx + 2'h1;
      // video request: same clear-on-ack unless another pending
      if (link.video_dma_ack && !vack_q)
        vreq <= video_request_in;
      else if (video_request_in)
        vreq <= 1'b1;
    end
  end

  // request drops for each ack cycle and returns only while room remains after the word in flight
  assign link.sound_dma_request = ~fifo_full && !(ack_rise && fifo_cnt == 3'(FIFO_DEPTH - 1))
    && !link.sound_dma_ack;
  assign link.video_dma_request = vreq;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      us_cnt <= 8'h0;
      per_cnt <= '0;
      slot_cyc <= '0;
      slot_len <= '0;
      latch <= SILENT_BYTE;
      latch_valid <= 1'b0;
      seq_cnt <= 3'h0;
    end else begin
      us_cnt <= us_tick ? 8'h0 : us_cnt + 8'h1;
      if (us_tick)
        per_cnt <= slot_end ? '0 : per_cnt + PERIOD_W'(1);
      slot_cyc <= slot_end ? '0 : slot_cyc + 16'h1;
      if (slot_end) begin
        slot_len <= slot_cyc + 16'h1;
        latch <= next_byte;
        latch_valid <= !fifo_empty;
        seq_cnt <= (seq_cnt + 3'h1) & chan_mask;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs; decode chord and point into a 7-bit code
  // ------------------------------------------------------------------
  wire [2:0] chord = latch[CHORD_LSB +: 3];
  wire [3:0] point = latch[POINT_LSB +: 4];
  wire sign = latch[SIGN_BIT];
  logic [3:0] video_pipe;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_code <= '0;
      pair_plus <= 1'b0;
      pair_minus <= 1'b0;
      side_right <= 1'b0;
      mute <= 1'b1;
      sound_digital_out <= 4'h0;
      video_pipe <= 4'h0;
      video_digital_out <= 4'h0;
      cur_chan <= 3'h0;
      slot_pulse <= 1'b0;
    end else begin
      dac_code <= {chord, point};
      mute <= in_mute;
      side_right <= on_right;
      pair_plus <= !in_mute && !sign;
      pair_minus <= !in_mute && sign;
      sound_digital_out <= in_mute ? 4'h0 : {on_right, sign, chord[2:1]};
      video_pipe <= in_mute ? 4'h0 : {on_right, sign, chord[2:1]};
      video_digital_out <= video_pipe;
      cur_chan <= seq_cnt;
      slot_pulse <= slot_end;
    end
  end
endmodule // msd_sequencer

/* File: rtl/msd_supplier.sv */
/*
  DMA supplier end: AXI4-Lite slave holding control registers and a
  word slot; hands the word to the sequencer on request with an ack pulse.
  Assumes one clock; drives control straight to the sequencer ports.
*/
`timescale 1ns/1ps
module msd_supplier (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // link
  msd_if.supplier link,
  // control to sequencer
  output logic [1:0] chan_mode,
  output logic [msd_pkg::PERIOD_W-1:0] sample_period_register,
  output logic [3*msd_pkg::NUM_POS-1:0] stereo_pos
);
  import msd_pkg::*;

  // ------------------------------------------------------------------
  // register access
  // ------------------------------------------------------------------
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [31:0] word_q;
  logic word_full;
  logic ack;
  wire do_write = aw_hold && w_hold && !s_bvalid;
  wire wr_data = do_write && aw_q == OFF_DATA;
  wire wr_ok = aw_q == OFF_CTRL || aw_q == OFF_PERIOD || aw_q == OFF_STEREO ||
               (aw_q == OFF_DATA && !word_full);
  wire send = link.sound_dma_request && word_full && !ack;
  wire [31:0] rd_mux =
    (s_araddr == OFF_CTRL) ? {30'h0, chan_mode} :
    (s_araddr == OFF_PERIOD) ? {24'h0, sample_period_register} :
    (s_araddr == OFF_STEREO) ? {8'h0, stereo_pos} :
    (s_araddr == OFF_STATUS) ? {30'h0, link.video_dma_request, word_full} : 32'h0;
  wire rd_hit = s_araddr == OFF_CTRL || s_araddr == OFF_PERIOD ||
                s_araddr == OFF_STEREO || s_araddr == OFF_STATUS;

  assign s_awready = !aw_hold;
  assign s_wready = !w_hold;
  assign s_arready = !s_rvalid;
  assign link.sound_dma_ack = ack;
  assign link.sound_data = word_q;
  assign link.video_dma_ack = link.video_dma_request;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h0;
      w_q <= 32'h0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= RESP_OKAY;
      chan_mode <= CHMODE_RESET;
      sample_period_register <= PERIOD_RESET;
      stereo_pos <= STEREO_RESET;
      word_q <= 32'h0;
      word_full <= 1'b0;
      ack <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold <= 1'b1;
        aw_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold <= 1'b1;
        w_q <= s_wdata;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (aw_q == OFF_CTRL)
          chan_mode <= w_q[1:0];
        if (aw_q == OFF_PERIOD)
          sample_period_register <= w_q[PERIOD_W-1:0];
        if (aw_q == OFF_STEREO)
          stereo_pos <= w_q[23:0];
      end else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
      ack <= send;
      if (wr_data && !word_full) begin
        word_q <= w_q;
        word_full <= 1'b1;
      end else if (ack)
        word_full <= 1'b0;
    end
  end
endmodule // msd_supplier

/* File: tb/msd_properties.sv */
/*
  Link checker for the sound sequencer and its DMA supplier.
  Assumes it is instantiated beside the msd_if link, on aclk.
*/
`timescale 1ns/1ps
module msd_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link signals
  input wire logic sound_dma_request,
  input wire logic sound_dma_ack,
  input wire logic [31:0] sound_data,
  input wire logic video_dma_request,
  input wire logic video_dma_ack
);
  // acks since reset, saturating
  logic [2:0] acks;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acks <= 3'h0;
    end else if (sound_dma_ack && acks != 3'h7) begin
      acks <= acks + 3'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_reset_exit;
    $rose(aresetn);
  endsequence
  sequence s_early_ack;
    sound_dma_ack && acks < 3'h3;
  endsequence

  AST_ACK_PULSE: assert property (sound_dma_ack |=> !sound_dma_ack)
    else $error("ack held longer than one cycle");
  AST_ACK_ON_REQ: assert property (sound_dma_ack |-> $past(sound_dma_request))
    else $error("ack without request");
  AST_RESET_EXIT: assert property (s_reset_exit |-> sound_dma_request && !sound_dma_ack)
    else $error("empty fifo not requesting after reset");
  AST_REQ_DROP: assert property (sound_dma_ack |-> !sound_dma_request)
    else $error("request not cleared by ack");
  AST_FALL_ON_ACK: assert property ($fell(sound_dma_request) |-> sound_dma_ack)
    else $error("request dropped without ack");
  AST_ROOM_HELD: assert property (acks < 3'h4 && !sound_dma_ack |-> sound_dma_request)
    else $error("request low with fifo room");
  AST_REQ_BACK: assert property (s_early_ack |=> sound_dma_request)
    else $error("request not back after early ack");
  AST_VIDEO_ECHO: assert property (video_dma_ack == video_dma_request)
    else $error("video ack differs from request");

  cover property (sound_dma_ack && sound_data != 32'h0);
endmodule // msd_properties

/* File: tb/tb.sv */
/*
  Self-checking bench: supplier and sequencer joined over msd_if.
  Assumes a 250 MHz aclk; AXI4-Lite master tasks drive the supplier.
*/
`timescale 1ns/1ps
module tb;
  import msd_pkg::*;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr, araddr, period;
  logic awvalid, wvalid, bready, arvalid, rready, vreq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, chan_mode;
  logic [3:0] wstrb, sdo, vdo, sd_d;
  logic [23:0] stereo, st;
  logic [6:0] dac_code;
  logic pplus, pminus, side_right, mute, slot_pulse;
  logic [2:0] cur_chan;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  integer seed = 32'hac6cbe9d;
  logic [7:0] q[$];
  msd_if link();

  msd_supplier msd_supplier_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .link(link),
    .chan_mode(chan_mode), .sample_period_register(period), .stereo_pos(stereo));
  msd_sequencer msd_sequencer_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
    .chan_mode(chan_mode), .sample_period_register(period), .stereo_pos(stereo),
    .video_request_in(vreq), .dac_code(dac_code), .pair_plus(pplus), .pair_minus(pminus),
    .side_right(side_right), .mute(mute), .sound_digital_out(sdo), .video_digital_out(vdo),
    .cur_chan(cur_chan), .slot_pulse(slot_pulse));
  msd_properties msd_properties_inst (.aclk(aclk), .aresetn(aresetn),
    .sound_dma_request(link.sound_dma_request), .sound_dma_ack(link.sound_dma_ack),
    .sound_data(link.sound_data), .video_dma_request(link.video_dma_request),
    .video_dma_ack(link.video_dma_ack));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  function automatic logic [6:0] f_code(input logic [7:0] b);
    return b[7:1];
  endfunction
  function automatic logic f_right(input logic [2:0] pos);
    return pos == 3'h7;
  endfunction

  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_b(input logic g, input logic e);
    cmp_w({31'h0, g}, {31'h0, e});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // watch n slots of 3 us each
  task automatic play(input int n);
    logic [31:0] k;
    logic [7:0] b;
    logic [2:0] pc;
    do @(posedge aclk); while (!slot_pulse);
    for (int j = 0; j < n; j++) begin
      k = 0;
      do begin
        @(posedge aclk);
        k++;
        if (k == 182) cmp_b(mute, 1'b1);
        if (k == 192 && !mute) begin
          cmp_b(q.size() != 0, 1'b1);
          b = q.pop_front();
          cmp_w({25'h0, dac_code}, {25'h0, f_code(b)});
          cmp_b(pminus, b[0]);
          cmp_b(pplus, ~b[0]);
          cmp_b(side_right, f_right(st[3*cur_chan +: 3]));
          if (j > 0) cmp_w({29'h0, cur_chan}, {29'h0, pc + 3'h1});
        end
        if (k == 192) pc = cur_chan;
        if (k == 744 && !mute) cmp_b(side_right, 1'b1);
      end while (!slot_pulse && k < 800);
      cmp_w(k, 32'd750);
    end
  endtask

  always @(posedge aclk) begin
    cyc++;
    vreq <= 1'($random(seed));
    sd_d <= sdo;
    if (cyc > 20) cmp_w({28'h0, vdo}, {28'h0, sd_d});
    if (cyc == 60000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      print_verdict;
    end
  end

  initial begin : main
    logic [31:0] d, w;
    logic [1:0] r;
    int i;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {vreq, sd_d, st} = '0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFF_CTRL, d, r);
    cmp_w(d, {30'h0, CHMODE_RESET});
    axr(OFF_PERIOD, d, r);
    cmp_w(d, {24'h0, PERIOD_RESET});
    axr(OFF_STEREO, d, r);
    cmp_w(d, {8'h0, STEREO_RESET});
    axr(8'h14, d, r);
    cmp_w({d[31:2], r}, {30'h0, RESP_SLVERR});
    for (int m = 0; m < 4; m++) begin
      axw(OFF_CTRL, m, r);
      axw(OFF_PERIOD, (m == 0) ? 32'h1 : 32'h3, r);
      play(2);
    end
    w = $random(seed);
    st = w[23:0];
    axw(OFF_STEREO, w, r);
    do @(posedge aclk); while (!slot_pulse);
    i = 0;
    r = RESP_OKAY;
    while (i < 8 && r === RESP_OKAY) begin
      w = (i == 0) ? 32'h80FF0100 : $random(seed);
      axw(OFF_DATA, w, r);
      if (r === RESP_OKAY) for (int n = 0; n < 4; n++) q.push_back(w[8*n +: 8]);
      i++;
    end
    cmp_w({30'h0, r}, {30'h0, RESP_SLVERR});
    axr(OFF_STATUS, d, r);
    cmp_w({31'h0, d[0]}, 32'h1);
    play(q.size() + 3);
    cmp_w(32'(q.size()), 32'h0);
    print_verdict;
  end
endmodule // tb
